// ### rtl/ddul_top.sv
// file: dual dac update latch with apb register slave
`timescale 1ns/1ps
module ddul_top
   import ddul_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   ce_i,
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [7:0]             paddr_i,
   input  wire logic [31:0]            pwdata_i,
   output logic      [31:0]            prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   input  wire logic                   tmr2_ovf_i,
   input  wire logic                   tmr3_ovf_i,
   input  wire logic                   tmr4_ovf_i,
   output logic      [DDUL_CODE_W-1:0] dac_a_code_o,
   output logic      [DDUL_CODE_W-1:0] dac_b_code_o,
   output logic                        dac_a_drive_en_o,
   output logic                        dac_b_drive_en_o,
   input  wire logic                   core_ready_i
);
   logic [7:0]  ctl_r   [DDUL_NCH];
   logic [7:0]  ctl_nxt [DDUL_NCH];
   logic [7:0]  lo_r    [DDUL_NCH];
   logic [7:0]  lo_nxt  [DDUL_NCH];
   logic [7:0]  hi_r    [DDUL_NCH];
   logic [7:0]  hi_nxt  [DDUL_NCH];
   logic [15:0] lat_r   [DDUL_NCH];
   logic [15:0] lat_nxt [DDUL_NCH];
   logic [DDUL_CODE_W-1:0] code_r   [DDUL_NCH];
   logic [DDUL_CODE_W-1:0] code_nxt [DDUL_NCH];
   logic        load_req [DDUL_NCH];
   logic        wr_xfer, rd_ok, dec_ok;
   logic [0:0]  sel_ch;
   logic [7:0]  off;
   logic [31:0] rdata_r, rdata_nxt;
   ddul_tmr_t   tmr;
   ddul_load_t  fin, fout;
   logic        fin_valid, fin_ready, fout_valid;

   assign tmr.tmr2 = tmr2_ovf_i;
   assign tmr.tmr3 = tmr3_ovf_i;
   assign tmr.tmr4 = tmr4_ovf_i;

   // apb decode; stall whole access while the fifo is full
   assign sel_ch  = paddr_i[4];
   assign off     = paddr_i & ~DDUL_CH_STRIDE;
   assign dec_ok  = (paddr_i[7:5] == 3'h0 && (off == DDUL_ADDR_A_LO
                     || off == DDUL_ADDR_A_HI || off == DDUL_ADDR_A_CN))
                    || paddr_i == DDUL_ADDR_STAT;
   assign pready_o  = fin_ready;
   assign pslverr_o = psel_i & penable_i & ~dec_ok;
   assign wr_xfer   = psel_i & penable_i & pready_o & pwrite_i & dec_ok
                      & ce_i;
   assign rd_ok     = psel_i & ~penable_i & ~pwrite_i;
   assign prdata_o  = rdata_r;

   // placement of the 12-bit word inside the 16-bit pair
   function automatic logic [DDUL_CODE_W-1:0] ddul_place(
      input logic [15:0] pair,
      input logic [2:0]  fmt
   );
      logic [15:0] sh;
      sh = pair;
      case (fmt)
         3'h0: sh = pair >> DDUL_SH_0;
         3'h1: sh = pair >> DDUL_SH_1;
         3'h2: sh = pair >> DDUL_SH_2;
         3'h3: sh = pair >> DDUL_SH_3;
         3'h4: sh = pair >> DDUL_SH_4;
         default: sh = pair >> DDUL_SH_0;
      endcase
      return sh[DDUL_CODE_W-1:0];
   endfunction

   genvar g;
   generate
      for (g = 0; g < DDUL_NCH; g++) begin : gen_ch
         logic       hit, my_tmr;
         logic [1:0] md;
         assign hit = wr_xfer && sel_ch == 1'(g)
                      && paddr_i[7:5] == 3'h0;
         assign md  = ctl_r[g][DDUL_MD_HI:DDUL_MD_LO];
         always_comb begin
            case (md)
               DDUL_MD_TMR3: my_tmr = tmr.tmr3;
               DDUL_MD_TMR4: my_tmr = tmr.tmr4;
               DDUL_MD_TMR2: my_tmr = tmr.tmr2;
               default:      my_tmr = 1'b0;
            endcase
         end
         always_comb begin
            ctl_nxt[g] = ctl_r[g];
            lo_nxt[g]  = lo_r[g];
            hi_nxt[g]  = hi_r[g];
            load_req[g] = 1'b0;
            if (hit && off == DDUL_ADDR_A_CN) begin
               ctl_nxt[g] = pwdata_i[7:0] & DDUL_CN_MASK;
            end
            if (hit && off == DDUL_ADDR_A_LO) begin
               lo_nxt[g] = pwdata_i[7:0];
            end
            if (hit && off == DDUL_ADDR_A_HI) begin
               hi_nxt[g] = pwdata_i[7:0];
               if (md == DDUL_MD_DEMAND) begin
                  load_req[g] = 1'b1;
               end
            end
            if (md != DDUL_MD_DEMAND && my_tmr) begin
               load_req[g] = 1'b1;
            end
         end
         always_comb begin
            lat_nxt[g]  = lat_r[g];
            code_nxt[g] = code_r[g];
            if (fout_valid && core_ready_i && fout.ch == 1'(g)) begin
               lat_nxt[g]  = fout.pair;
               code_nxt[g] = ddul_place(fout.pair,
                              ctl_r[g][DDUL_DF_HI:DDUL_DF_LO]);
            end
         end
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               ctl_r[g]  <= DDUL_CN_RST;
               lo_r[g]   <= DDUL_BYTE_RST;
               hi_r[g]   <= DDUL_BYTE_RST;
               lat_r[g]  <= DDUL_PAIR_RST;
               code_r[g] <= DDUL_CODE_RST;
            end else if (ce_i) begin
               ctl_r[g]  <= ctl_nxt[g];
               lo_r[g]   <= lo_nxt[g];
               hi_r[g]   <= hi_nxt[g];
               lat_r[g]  <= lat_nxt[g];
               code_r[g] <= code_nxt[g];
            end
         end
      end
   endgenerate

   // load requests queue into the fifo; when both fire only channel a is queued and the channel b request is dropped
   always_comb begin
      fin_valid = load_req[0] | load_req[1];
      fin.ch    = load_req[0] ? 1'b0 : 1'b1;
      fin.pair  = load_req[0] ? {hi_nxt[0], lo_nxt[0]}
                              : {hi_nxt[1], lo_nxt[1]};
   end

   ddul_fifo #(
      .WIDTH ($bits(ddul_load_t)),
      .DEPTH (DDUL_FIFO_D)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .in_data_i   (fin),
      .in_valid_i  (fin_valid),
      .in_ready_o  (fin_ready),
      .out_data_o  (fout),
      .out_valid_o (fout_valid),
      .out_ready_i (core_ready_i)
   );

   // read data captured in setup phase
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_ok) begin
         rdata_nxt = '0;
         case (off)
            DDUL_ADDR_A_LO: rdata_nxt[7:0] = lo_r[sel_ch];
            DDUL_ADDR_A_HI: rdata_nxt[7:0] = lat_r[sel_ch][15:8];
            DDUL_ADDR_A_CN: rdata_nxt[7:0] = ctl_r[sel_ch];
            default:        rdata_nxt = '0;
         endcase
         if (paddr_i == DDUL_ADDR_STAT) begin
            rdata_nxt = {30'h0, fout_valid, ~fin_ready};
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= '0;
      end else if (ce_i) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign dac_a_code_o     = code_r[0];
   assign dac_b_code_o     = code_r[1];
   assign dac_a_drive_en_o = ctl_r[0][DDUL_EN_BIT];
   assign dac_b_drive_en_o = ctl_r[1][DDUL_EN_BIT];
endmodule

// ### rtl/ddul_pkg.sv
// package: constants and types for the dual dac update latch
package ddul_pkg;
   localparam int          DDUL_NCH       = 2;
   localparam int          DDUL_CODE_W    = 12;
   localparam int          DDUL_FIFO_D    = 8;
   localparam logic [7:0]  DDUL_ADDR_A_LO = 8'h00;
   localparam logic [7:0]  DDUL_ADDR_A_HI = 8'h04;
   localparam logic [7:0]  DDUL_ADDR_A_CN = 8'h08;
   localparam logic [7:0]  DDUL_ADDR_B_LO = 8'h10;
   localparam logic [7:0]  DDUL_ADDR_B_HI = 8'h14;
   localparam logic [7:0]  DDUL_ADDR_B_CN = 8'h18;
   localparam logic [7:0]  DDUL_ADDR_STAT = 8'h20;
   localparam logic [7:0]  DDUL_CH_STRIDE = 8'h10;
   localparam int          DDUL_EN_BIT    = 7;
   localparam int          DDUL_MD_HI     = 4;
   localparam int          DDUL_MD_LO     = 3;
   localparam int          DDUL_DF_HI     = 2;
   localparam int          DDUL_DF_LO     = 0;
   localparam logic [7:0]  DDUL_CN_RST    = 8'h00;
   localparam logic [7:0]  DDUL_BYTE_RST  = 8'h00;
   localparam logic [11:0] DDUL_CODE_RST  = 12'h000;
   localparam logic [15:0] DDUL_PAIR_RST  = 16'h0000;
   localparam logic [7:0]  DDUL_CN_MASK   = 8'h9f;

   typedef enum logic [1:0] {
      DDUL_MD_DEMAND = 2'b00,
      DDUL_MD_TMR3   = 2'b01,
      DDUL_MD_TMR4   = 2'b10,
      DDUL_MD_TMR2   = 2'b11
   } ddul_mode_t;

   typedef enum logic [2:0] {
      DDUL_DF_R0 = 3'b000,
      DDUL_DF_R1 = 3'b001,
      DDUL_DF_R2 = 3'b010,
      DDUL_DF_R3 = 3'b011,
      DDUL_DF_R4 = 3'b100
   } ddul_fmt_unused_t;

   // shift amounts for format codes 0..4
   localparam logic [3:0] DDUL_SH_0 = 4'h0;
   localparam logic [3:0] DDUL_SH_1 = 4'h1;
   localparam logic [3:0] DDUL_SH_2 = 4'h2;
   localparam logic [3:0] DDUL_SH_3 = 4'h3;
   localparam logic [3:0] DDUL_SH_4 = 4'h4;

   typedef struct packed {
      logic        lo_wr;
      logic        hi_wr;
      logic [7:0]  wdata;
   } ddul_wr_t;

   typedef struct packed {
      logic [0:0]  ch;
      logic [15:0] pair;
   } ddul_load_t;

   typedef struct packed {
      logic tmr2;
      logic tmr3;
      logic tmr4;
   } ddul_tmr_t;
endpackage

// ### rtl/ddul_fifo.sv
// file: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ddul_fifo
   import ddul_pkg::*;
#(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o  = mem_r[rp_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_comb begin
      wp_nxt  = push ? wp_r + AW'(1) : wp_r;
      rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (ce_i) begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage has no reset; contents gated by count
   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end
endmodule

// ### test/ddul_asserts.sv
// checker: port assertions for the dual dac update latch
`timescale 1ns/1ps
module ddul_asserts
   import ddul_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        ce_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        tmr2_ovf_i,
   input wire logic        tmr3_ovf_i,
   input wire logic        tmr4_ovf_i,
   input wire logic [11:0] dac_a_code_o,
   input wire logic [11:0] dac_b_code_o,
   input wire logic        dac_a_drive_en_o,
   input wire logic        dac_b_drive_en_o
);
   logic       tk;
   logic       ovf;
   logic [1:0] md_a_r;
   assign tk  = psel_i && penable_i && pwrite_i && pready_o && ce_i;
   assign ovf = tmr2_ovf_i || tmr3_ovf_i || tmr4_ovf_i;
   // mode shadow of channel a
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
         md_a_r <= 2'b00;
      else if (tk && paddr_i == DDUL_ADDR_A_CN)
         md_a_r <= pwdata_i[DDUL_MD_HI:DDUL_MD_LO];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_wr(logic [7:0] a);
      tk && paddr_i == a;
   endsequence
   property p_rst;
      $rose(rst_n_i) |-> dac_a_code_o == 12'h000 && dac_b_code_o == 12'h000
         && !dac_a_drive_en_o && !dac_b_drive_en_o;
   endproperty
   property p_en_a;
      s_wr(DDUL_ADDR_A_CN) |=> dac_a_drive_en_o == $past(pwdata_i[7]);
   endproperty
   property p_en_b;
      s_wr(DDUL_ADDR_B_CN) |=> dac_b_drive_en_o == $past(pwdata_i[7]);
   endproperty
   property p_hold_a;
      $changed(dac_a_drive_en_o) |-> $past(tk && paddr_i == DDUL_ADDR_A_CN);
   endproperty
   property p_hold_b;
      $changed(dac_b_drive_en_o) |-> $past(tk && paddr_i == DDUL_ADDR_B_CN);
   endproperty
   property p_lo_a;
      s_wr(DDUL_ADDR_A_LO) ##0 !ovf |=> $stable(dac_a_code_o);
   endproperty
   property p_lo_b;
      s_wr(DDUL_ADDR_B_LO) ##0 !ovf |=> $stable(dac_b_code_o);
   endproperty
   property p_tmr_a;
      s_wr(DDUL_ADDR_A_HI) ##0 (md_a_r != 2'b00 && !ovf)
         |=> $stable(dac_a_code_o);
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not clear after reset");
   a_en_a: assert property (p_en_a)
      else $error("drive a differs from enable bit");
   a_en_b: assert property (p_en_b)
      else $error("drive b differs from enable bit");
   a_hold_a: assert property (p_hold_a)
      else $error("drive a moved without control write");
   a_hold_b: assert property (p_hold_b)
      else $error("drive b moved without control write");
   a_lo_a: assert property (p_lo_a)
      else $error("low byte write moved code a");
   a_lo_b: assert property (p_lo_b)
      else $error("low byte write moved code b");
   a_tmr_a: assert property (p_tmr_a)
      else $error("high byte write loaded in timer mode");
endmodule
bind ddul_top ddul_asserts u_chk (.*);

// ### test/tb.sv
// testbench: apb stimulus and checks for the dual dac update latch
`timescale 1ns/1ps
module tb;
   import ddul_pkg::*;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic        core_ready_i = 1'b1, tmr2_ovf_i = 1'b0;
   logic        tmr3_ovf_i = 1'b0, tmr4_ovf_i = 1'b0;
   logic [31:0] prdata_o;
   logic        pready_o, pslverr_o, dac_a_drive_en_o, dac_b_drive_en_o;
   logic [11:0] dac_a_code_o, dac_b_code_o;
   logic [11:0] last[2];
   logic [31:0] exp_q[$];
   int          errors = 0;
   int          cmp_count = 0;
   always #20 clk_i = ~clk_i;
   ddul_top dut (.*);
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 64);
      if (pready_o !== 1'b1) begin
         errors++;
         wrap_up();
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic nx(int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic st(int c, logic [11:0] e, logic d);
      chk("code", 32'(c ? dac_b_code_o : dac_a_code_o), 32'(e));
      chk("drive", 32'(c ? dac_b_drive_en_o : dac_a_drive_en_o), 32'(d));
   endtask
   task automatic pulse(logic [2:0] v);
      @(posedge clk_i);
      {tmr2_ovf_i, tmr3_ovf_i, tmr4_ovf_i} <= v;
      @(posedge clk_i);
      {tmr2_ovf_i, tmr3_ovf_i, tmr4_ovf_i} <= 3'b000;
   endtask
   // read results in order of issue
   always @(posedge clk_i) begin
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
         chk("read", prdata_o, exp_q.pop_front());
      end
      if (psel_i && penable_i && pready_o === 1'b1) begin
         chk("slverr", 32'(pslverr_o), 32'(paddr_i == 8'h30));
      end
   end
   initial begin
      logic [7:0] lo, hi, b;
      logic [2:0] sel;
      void'($urandom(20));
      last = '{12'h000, 12'h000};
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         b = c ? DDUL_CH_STRIDE : 8'h00;
         rd(b, 32'h0);
         rd(b + 8'h04, 32'h0);
         rd(b + 8'h08, 32'h0);
         nx(0);
         st(c, 12'h000, 1'b0);
         for (int f = 0; f < 8; f++) begin
            lo = 8'($urandom);
            hi = 8'($urandom);
            apb(1'b1, b + 8'h08, 32'h80 | 32'(f));
            apb(1'b1, b, {24'h0, lo});
            nx(0);
            st(c, last[c], 1'b1);
            apb(1'b1, b + 8'h04, {24'h0, hi});
            nx(1);
            last[c] = 12'({hi, lo} >> (f > 4 ? 0 : f));
            st(c, last[c], 1'b1);
            rd(b, {24'h0, lo});
            rd(b + 8'h04, {24'h0, hi});
            rd(b + 8'h08, 32'h80 | 32'(f));
         end
      end
      $display("test formats done");
      for (int m = 1; m < 4; m++) begin
         sel = m == 1 ? 3'b010 : (m == 2 ? 3'b001 : 3'b100);
         lo = 8'($urandom);
         hi = 8'($urandom);
         apb(1'b1, 8'h08, 32'(m) << 3);
         apb(1'b1, 8'h00, {24'h0, lo});
         apb(1'b1, 8'h04, {24'h0, hi});
         nx(1);
         st(0, last[0], 1'b0);
         pulse(~sel);
         nx(1);
         st(0, last[0], 1'b0);
         pulse(sel);
         nx(1);
         last[0] = {hi[3:0], lo};
         st(0, last[0], 1'b0);
         rd(8'h04, {24'h0, hi});
         rd(8'h00, {24'h0, lo});
      end
      $display("test timer modes done");
      apb(1'b1, 8'h30, 32'hff);
      rd(8'h30, 32'h0);
      apb(1'b1, 8'h08, 32'h80);
      apb(1'b1, 8'h00, 32'h0);
      core_ready_i <= 1'b0;
      for (int k = 1; k < 9; k++)
         apb(1'b1, 8'h04, 32'(k));
      nx(0);
      chk("ready", 32'(pready_o), 32'h0);
      st(0, last[0], 1'b1);
      @(posedge clk_i);
      core_ready_i <= 1'b1;
      for (int k = 1; k < 9; k++) begin
         nx(1);
         st(0, 12'(k << 8), 1'b1);
      end
      last[0] = 12'h800;
      st(0, 12'h800, 1'b1);
      rd(DDUL_ADDR_STAT, 32'h0);
      ce_i <= 1'b0;
      apb(1'b1, 8'h04, 32'h0f);
      ce_i <= 1'b1;
      nx(2);
      st(0, 12'h800, 1'b1);
      rd(8'h04, 32'h08);
      $display("test queue done");
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      nx(0);
      st(0, 12'h000, 1'b0);
      st(1, 12'h000, 1'b0);
      rd(8'h14, 32'h0);
      $display("test second reset done");
      wrap_up();
   end
endmodule
